/* verilog/dcb_pkg.sv */
// Package of constants for the command and burst engine
package dcb_pkg;
    // Command encodings as {ras_b, cas_b, we_b} with chip select low
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_NOP = 3'h7;
    // Address bit that requests auto precharge on reads and writes
    localparam int AP_BIT = 10;
    // Mode register selects, additive and CAS latency fields
    localparam logic [2:0] MR_SEL_MODE = 3'h0;
    localparam logic [2:0] MR_SEL_EXT = 3'h1;
    localparam int AL_LSB = 3;
    localparam int CL_LSB = 4;
    localparam logic [2:0] AL_MAX = 3'h6;
    // Burst length field and its codes
    localparam int BL_LSB = 0;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    // Reset defaults of latencies and burst length, and the burst length of eight
    localparam logic [2:0] AL_RST = 3'h0;
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [3:0] BL_RST = 4'h4;
    localparam logic [3:0] BL_EIGHT = 4'h8;
    // Depth of the command latency line; the taps set the delay
    localparam int LAT_DEPTH = 16;
endpackage : dcb_pkg

/* verilog/dcb_engine.sv */
// Command decoder, burst engine and write data FIFO
module dcb_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    // Storage array and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic full;
    logic empty;
    // Full when pointers differ only in the wrap bit
    assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty = (wr_ptr_ff == rd_ptr_ff);
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data = mem[rd_ptr_ff[AW-1:0]];
    // Pointer update; memory has no reset to stay a plain RAM
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (i_valid && !full) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (i_ready && !empty) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
    // Array write
    always_ff @(posedge i_clk_sys) begin
        if (i_valid && !full) begin
            mem[wr_ptr_ff[AW-1:0]] <= i_data;
        end
    end
endmodule : dcb_fifo

// Function
// - Decode commands from sampled control pins
// - Additive latency from extended mode field
// - Deselect accepts nothing, bursts continue
// - No-operation registers nothing new
// - Activate opens bank row until precharge
// - Column start, address bit auto precharge
// - Read data at additive plus CAS latency
// - Strobe low before first, during last
// - Data lines released after read burst
// - Back-to-back reads half burst apart
// - Masked elements leave location unchanged
// - Write latency is read latency minus one
// - Write data captured on rising strobe edges
// - Recovery counted from end of write data
// - Power-down performs no refresh
module dcb_engine #(
    parameter int BANKS = 8,
    parameter int ROW_W = 13,
    parameter int COL_W = 10,
    parameter int DQ_W = 16,
    parameter int MEM_WORDS = 64
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Command pins, all asynchronous to the system clock
    input wire logic i_ck,
    input wire logic i_cke,
    input wire logic i_cs_b,
    input wire logic i_ras_b,
    input wire logic i_cas_b,
    input wire logic i_we_b,
    input wire logic [2:0] i_ba,
    input wire logic [ROW_W-1:0] i_addr,
    // Data pins, split into in, out and enable
    input wire logic [DQ_W-1:0] i_dq,
    output logic [DQ_W-1:0] o_dq,
    output logic o_dq_oe,
    input wire logic i_dm,
    input wire logic i_dqs,
    output logic o_dqs,
    output logic o_dqs_b,
    output logic o_dqs_oe,
    // Status
    output logic [BANKS-1:0] o_bank_open,
    output logic o_wr_recovery
);
    localparam int MAW = $clog2(MEM_WORDS);
    // Entry: valid, write flag, bank, column, auto precharge
    localparam int ENT_W = 1 + 1 + 3 + COL_W + 1;
    localparam int LAT_DEPTH = dcb_pkg::LAT_DEPTH;

    // Burst engine states
    typedef enum logic [2:0] {
        DCB_IDLE = 3'b001,
        DCB_READ = 3'b010,
        DCB_WRITE = 3'b100
    } dcb_state_e;

    // Module state apart from the memory array and write queue
    typedef struct packed {
        logic [2:0] ck_sync;
        logic [1:0] cke_sync;
        logic [1:0] cs_sync;
        logic [1:0] ras_sync;
        logic [1:0] cas_sync;
        logic [1:0] we_sync;
        logic [5:0] ba_sync;
        logic [2*ROW_W-1:0] addr_sync;
        logic [2:0] dqs_sync;
        logic [2*DQ_W-1:0] dq_sync;
        logic [1:0] dm_sync;
        logic [2:0] al;
        logic [2:0] cl;
        logic [3:0] bl;
        logic [BANKS-1:0] open;
        logic [LAT_DEPTH*ENT_W-1:0] pipe;
        dcb_state_e st;
        logic [2:0] bank;
        logic [COL_W-1:0] col;
        logic ap;
        logic [3:0] left;
        logic [DQ_W-1:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_oe;
        logic wrec;
    } dcb_state_s;

    dcb_state_s state_ff;
    dcb_state_s nxt_state;
    // Memory array kept small; only the low column bits select a word, the bank is dropped
    logic [DQ_W-1:0] mem_ff [MEM_WORDS];

    // Pin shorthands after the two-flop synchroniser
    logic ck_rise;
    logic cmd_valid;
    logic [2:0] cmd;
    logic dqs_rise;
    logic [ENT_W-1:0] pipe_out;
    logic [ENT_W-1:0] pipe_wr;
    logic [ENT_W-1:0] pipe_in;
    logic [MAW-1:0] rd_index;
    logic fifo_ready;
    logic fifo_valid;
    logic [DQ_W+MAW:0] fifo_data;
    logic [DQ_W+MAW:0] fifo_in;

    // Map bank and column to a word of the array
    function automatic logic [MAW-1:0] word_index(input logic [2:0] b,
                                                   input logic [COL_W-1:0] c);
        logic [COL_W+2:0] flat;
        flat = {b, c};
        return flat[MAW-1:0];
    endfunction

    // Edge of the link clock seen only on the second and third stages
    assign ck_rise = state_ff.ck_sync[1] && !state_ff.ck_sync[2];
    assign dqs_rise = state_ff.dqs_sync[1] && !state_ff.dqs_sync[2];
    // Chip select high or clock enable low accepts nothing
    // No power-down state exists, so nothing here can skip a refresh
    assign cmd_valid = ck_rise && state_ff.cke_sync[1] && !state_ff.cs_sync[1];
    assign cmd = {state_ff.ras_sync[1], state_ff.cas_sync[1], state_ff.we_sync[1]};
    // Read tap arms one link cycle before data, write tap one before strobe
    assign pipe_out = state_ff.pipe[ENT_W*(state_ff.al + state_ff.cl - 2) +: ENT_W];
    assign pipe_wr = state_ff.pipe[ENT_W*(state_ff.al + state_ff.cl - 3) +: ENT_W];
    assign rd_index = word_index(state_ff.bank, state_ff.col);

    // Captured elements carry their own word, as the column moves on at capture
    assign fifo_in = {rd_index, state_ff.dm_sync[1], state_ff.dq_sync[2*DQ_W-1:DQ_W]};

    dcb_fifo #(
        .WIDTH(DQ_W + 1 + MAW),
        .DEPTH(32)
    ) u_wfifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_valid(state_ff.st == DCB_WRITE && dqs_rise && state_ff.left != 4'h0),
        .i_data(fifo_in),
        .o_ready(fifo_ready),
        .o_valid(fifo_valid),
        .o_data(fifo_data),
        .i_ready(1'b1)
    );

    // Next-state logic for decoder and burst engine
    always_comb begin
        nxt_state = state_ff;
        pipe_in = '0;
        // Synchroniser shift; first stage is read by the second only
        nxt_state.ck_sync = {state_ff.ck_sync[1:0], i_ck};
        nxt_state.dqs_sync = {state_ff.dqs_sync[1:0], i_dqs};
        nxt_state.cke_sync = {state_ff.cke_sync[0], i_cke};
        nxt_state.cs_sync = {state_ff.cs_sync[0], i_cs_b};
        nxt_state.ras_sync = {state_ff.ras_sync[0], i_ras_b};
        nxt_state.cas_sync = {state_ff.cas_sync[0], i_cas_b};
        nxt_state.we_sync = {state_ff.we_sync[0], i_we_b};
        nxt_state.ba_sync = {state_ff.ba_sync[2:0], i_ba};
        nxt_state.addr_sync = {state_ff.addr_sync[ROW_W-1:0], i_addr};
        nxt_state.dq_sync = {state_ff.dq_sync[DQ_W-1:0], i_dq};
        nxt_state.dm_sync = {state_ff.dm_sync[0], i_dm};
        // Command decode on each rising link clock edge
        if (cmd_valid) begin
            case (cmd)
                // Mode load; controller keeps banks idle
                dcb_pkg::CMD_LOAD_MODE: begin
                    if (state_ff.ba_sync[5:3] == dcb_pkg::MR_SEL_EXT) begin
                        if (state_ff.addr_sync[ROW_W+dcb_pkg::AL_LSB +: 3]
                            <= dcb_pkg::AL_MAX) begin
                            nxt_state.al = state_ff.addr_sync[ROW_W+dcb_pkg::AL_LSB +: 3];
                        end
                    end else if (state_ff.ba_sync[5:3] == dcb_pkg::MR_SEL_MODE) begin
                        nxt_state.cl = state_ff.addr_sync[ROW_W+dcb_pkg::CL_LSB +: 3];
                        nxt_state.bl = (state_ff.addr_sync[ROW_W+dcb_pkg::BL_LSB +: 3]
                            == dcb_pkg::BL_CODE_8) ? dcb_pkg::BL_EIGHT : dcb_pkg::BL_RST;
                    end
                end
                // Open a row; it stays open until precharge
                dcb_pkg::CMD_ACTIVATE: begin
                    nxt_state.open[state_ff.ba_sync[5:3]] = 1'b1;
                end
                // Close one bank or all banks
                dcb_pkg::CMD_PRECHARGE: begin
                    if (state_ff.addr_sync[ROW_W+dcb_pkg::AP_BIT]) begin
                        nxt_state.open = '0;
                    end else begin
                        nxt_state.open[state_ff.ba_sync[5:3]] = 1'b0;
                    end
                end
                // Reads and writes enter the latency line
                dcb_pkg::CMD_READ, dcb_pkg::CMD_WRITE: begin
                    pipe_in = {1'b1, ~state_ff.we_sync[1], state_ff.ba_sync[5:3],
                        state_ff.addr_sync[ROW_W +: COL_W],
                        state_ff.addr_sync[ROW_W+dcb_pkg::AP_BIT]};
                end
                // Refresh, no-operation: nothing new registered
                default: begin
                    pipe_in = '0;
                end
            endcase
        end
        // Latency line advances only on link clock edges
        if (ck_rise) begin
            nxt_state.pipe = {state_ff.pipe[(LAT_DEPTH-1)*ENT_W-1:0], pipe_in};
        end
        // Burst engine
        nxt_state.wrec = 1'b0;
        if (ck_rise) begin
            case (state_ff.st)
                DCB_IDLE: begin
                    nxt_state.dq_oe = 1'b0;
                    nxt_state.dqs_oe = 1'b0;
                end
                DCB_READ: begin
                    // Element per link edge, strobe low on last
                    nxt_state.dq = mem_ff[rd_index];
                    nxt_state.dq_oe = 1'b1;
                    nxt_state.dqs_oe = 1'b1;
                    nxt_state.dqs = (state_ff.left != 4'h1);
                    nxt_state.col = state_ff.col + 1'b1;
                    nxt_state.left = state_ff.left - 1'b1;
                    if (state_ff.left == 4'h1) begin
                        nxt_state.st = DCB_IDLE;
                        // Auto precharge closes the row
                        if (state_ff.ap) begin
                            nxt_state.open[state_ff.bank] = 1'b0;
                        end
                    end
                end
                DCB_WRITE: begin
                    if (state_ff.left == 4'h0) begin
                        // Recovery starts at end of data, mask ignored
                        nxt_state.wrec = 1'b1;
                        nxt_state.st = DCB_IDLE;
                        if (state_ff.ap) begin
                            nxt_state.open[state_ff.bank] = 1'b0;
                        end
                    end
                end
                default: begin
                    nxt_state.st = DCB_IDLE;
                end
            endcase
            // A new burst at its latency tap takes over, giving gapless streams
            if (pipe_out[ENT_W-1] && !pipe_out[ENT_W-2]) begin
                nxt_state.bank = pipe_out[ENT_W-3 -: 3];
                nxt_state.col = pipe_out[COL_W:1];
                nxt_state.ap = pipe_out[0];
                nxt_state.left = state_ff.bl;
                nxt_state.dqs_oe = 1'b1;
                // Preamble: strobe low for one link cycle before data
                if (state_ff.st != DCB_READ) begin
                    nxt_state.dqs = 1'b0;
                end
                nxt_state.st = DCB_READ;
            end else if (pipe_wr[ENT_W-1] && pipe_wr[ENT_W-2]) begin
                // Armed a link cycle early so the first strobe edge is not missed
                nxt_state.bank = pipe_wr[ENT_W-3 -: 3];
                nxt_state.col = pipe_wr[COL_W:1];
                nxt_state.ap = pipe_wr[0];
                nxt_state.left = state_ff.bl;
                nxt_state.st = DCB_WRITE;
            end
        end
        // Write elements counted on rising strobe edges
        if (state_ff.st == DCB_WRITE && dqs_rise && state_ff.left != 4'h0) begin
            nxt_state.left = state_ff.left - 1'b1;
            nxt_state.col = state_ff.col + 1'b1;
        end
        // Hold the strobe low for the postamble when no burst follows
        if (nxt_state.st == DCB_IDLE && ck_rise && state_ff.st == DCB_READ) begin
            nxt_state.dqs = 1'b0;
        end
    end

    // Register the state copy
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= '0;
            state_ff.st <= DCB_IDLE;
            state_ff.al <= dcb_pkg::AL_RST;
            state_ff.cl <= dcb_pkg::CL_RST;
            state_ff.bl <= dcb_pkg::BL_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Array write of queued elements; masked elements left alone
    always_ff @(posedge i_clk_sys) begin
        if (fifo_valid && !fifo_data[DQ_W]) begin
            mem_ff[fifo_data[DQ_W+1 +: MAW]] <= fifo_data[DQ_W-1:0];
        end
    end

    // Outputs from flip-flops
    assign o_dq = state_ff.dq;
    assign o_dq_oe = state_ff.dq_oe;
    assign o_dqs = state_ff.dqs;
    assign o_dqs_b = !state_ff.dqs;
    assign o_dqs_oe = state_ff.dqs_oe;
    assign o_bank_open = state_ff.open;
    assign o_wr_recovery = state_ff.wrec;

    // Deselect leaves open rows untouched
    a_deselect_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (ck_rise && state_ff.cs_sync[1] && state_ff.st == DCB_IDLE)
        |=> (state_ff.open == $past(state_ff.open)))
        else $error("deselect changed bank state");
    // Strobe low with last read element
    a_last_strobe: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (ck_rise && state_ff.st == DCB_READ && state_ff.left == 4'h1) |=> !o_dqs)
        else $error("strobe not low on last element");
    // Lines released once idle
    a_release_dq: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (ck_rise && state_ff.st == DCB_IDLE && !pipe_out[ENT_W-1]) |=> !o_dq_oe)
        else $error("data lines still driven");
    // Activate opens its bank
    a_activate_open: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (cmd_valid && cmd == dcb_pkg::CMD_ACTIVATE)
        |=> o_bank_open[$past(state_ff.ba_sync[5:3])])
        else $error("activate did not open bank");
    // Recovery pulse when a write burst ends
    a_write_recovery: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (ck_rise && state_ff.st == DCB_WRITE && state_ff.left == 4'h0) |=> o_wr_recovery)
        else $error("no recovery pulse after write");
    // Fifo never refuses a captured element
    a_fifo_room: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        fifo_ready)
        else $error("write queue overflow");
endmodule : dcb_engine

/* verification/dcb_ctrl_model.sv */
// Memory controller model: link clock, commands and write bursts
module dcb_ctrl_model (
    // Link clock and command pins
    output logic ck,
    output logic cke,
    output logic cs_b,
    output logic ras_b,
    output logic cas_b,
    output logic we_b,
    output logic [2:0] ba,
    output logic [12:0] addr,
    // Write data lane
    output logic [15:0] dq,
    output logic dm,
    output logic dqs
);
    timeunit 1ns;
    timeprecision 1ps;

    // Free-running link clock, phase unrelated to the system clock
    initial begin
        ck = 1'b0;
        cke = 1'b1;
        {cs_b, ras_b, cas_b, we_b} = 4'hf;
        ba = 3'h0;
        addr = 13'h0000;
        dq = 16'h0000;
        dm = 1'b0;
        dqs = 1'b0;
        #7;
        forever #160 ck = ~ck;
    end

    // A command stands about one link cycle, then the device is deselected at the next falling edge
    always @(negedge ck) begin
        cke <= 1'b1;
        {cs_b, ras_b, cas_b, we_b} <= 4'hf;
        addr <= ~addr; // Don't-care pins keep moving
    end

    // Drive from mid-cycle so pins are steady at the rising edge
    task automatic cmd(input logic e, input logic s, input logic [2:0] op,
                       input logic [2:0] b, input logic [12:0] a);
        @(negedge ck);
        #1;
        cke = e;
        cs_b = s;
        {ras_b, cas_b, we_b} = op;
        ba = b;
        addr = a;
        @(posedge ck);
    endtask

    // Whole link cycles pass; callers use it for the spacing minimums
    task automatic idle(input int n);
        repeat (n) @(posedge ck);
    endtask

    // Whole write burst with its first strobe edge at the write latency
    task automatic wr(input logic [2:0] b, input logic [12:0] a, input int n,
                      input int wl, input logic [15:0] d [8], input logic [7:0] m);
        int i;
        cmd(1'b1, 1'b0, dcb_pkg::CMD_WRITE, b, a);
        repeat (wl - 1) @(posedge ck);
        // Never cut short, so a burst of four always completes
        for (i = 0; i < n; i++) begin
            @(negedge ck);
            dq = d[i];
            dm = m[i];
            dqs = 1'b0;
            @(posedge ck);
            #2 dqs = 1'b1;
        end
        @(negedge ck);
        dqs = 1'b0; // Postamble
        dq = ~dq; // Released lane shows no stale data
        dm = 1'b0;
    endtask
endmodule // dcb_ctrl_model

/* verification/dcb_engine_tb.sv */
// Self-checking bench for the command and burst engine
module dcb_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // System clock, reset and result counters
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    int errors = 0;
    int comparisons = 0;
    int rec_cnt = 0;
    // Controller side of the link
    logic ck, cke, cs_b, ras_b, cas_b, we_b, c_dm, c_dqs;
    logic [2:0] ba;
    logic [12:0] addr;
    logic [15:0] c_dq;
    // Device outputs and resolved two-way lanes
    logic [15:0] o_dq;
    logic [7:0] o_bank_open;
    logic o_dq_oe, o_dqs, o_dqs_b, o_dqs_oe, o_wr_recovery;
    wire logic [15:0] dq_bus = o_dq_oe ? o_dq : c_dq;
    wire logic dqs_bus = o_dqs_oe ? o_dqs : c_dqs;
    // Burst patterns
    logic [15:0] pa [8];
    logic [15:0] pb [8];

    always #20 i_clk_sys = ~i_clk_sys;
    // Count recovery pulses seen from the device
    always @(posedge i_clk_sys) if (o_wr_recovery === 1'b1) rec_cnt <= rec_cnt + 1;

    dcb_ctrl_model ctrl (.ck(ck), .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
        .we_b(we_b), .ba(ba), .addr(addr), .dq(c_dq), .dm(c_dm), .dqs(c_dqs));
    dcb_engine DUT (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ck(ck), .i_cke(cke),
        .i_cs_b(cs_b), .i_ras_b(ras_b), .i_cas_b(cas_b), .i_we_b(we_b), .i_ba(ba),
        .i_addr(addr), .i_dq(dq_bus), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dm(c_dm),
        .i_dqs(dqs_bus), .o_dqs(o_dqs), .o_dqs_b(o_dqs_b), .o_dqs_oe(o_dqs_oe),
        .o_bank_open(o_bank_open), .o_wr_recovery(o_wr_recovery));

    // Compare and count; case inequality lets no unknown pass
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Write burst, then exactly one recovery pulse after its data
    task automatic wr(input logic [2:0] b, input logic [12:0] a, input int n, input int wl,
                      input logic [15:0] d [8], input logic [7:0] m);
        int c0;
        c0 = rec_cnt;
        ctrl.wr(b, a, n, wl, d, m);
        ctrl.idle(2);
        chk("recovery pulses", 32'h0000_0001, 32'(rec_cnt - c0));
    endtask

    // Read burst sampled mid link cycle, where the output has settled
    task automatic rd(input logic [2:0] b, input logic [12:0] a, input int n, input int rl,
                      input logic pre, input logic [15:0] e [8]);
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_READ, b, a);
        repeat (rl - 1) @(posedge ck);
        @(negedge ck);
        #60;
        if (pre) chk("preamble strobe", 32'h1, 32'({o_dqs, o_dqs_b}));
        for (int i = 0; i < n; i++) begin
            @(negedge ck);
            #60;
            chk("read data", 32'(e[i]), 32'(o_dq));
            chk("read enable", 32'h1, 32'(o_dq_oe));
        end
        chk("postamble strobe", 32'h1, 32'({o_dqs, o_dqs_b}));
        @(negedge ck);
        #60;
        chk("lane released", 32'h0, 32'(o_dq_oe));
    endtask

    // Ignored commands, then open and close a row
    task automatic t_bank();
        ctrl.cmd(1'b0, 1'b0, dcb_pkg::CMD_ACTIVATE, 3'h1, 13'h0010);
        ctrl.cmd(1'b1, 1'b1, dcb_pkg::CMD_ACTIVATE, 3'h2, 13'h0020);
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_NOP, 3'h3, 13'h0030);
        ctrl.idle(2);
        chk("banks after ignored", 32'h0, 32'(o_bank_open));
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_ACTIVATE, 3'h3, 13'h1abc);
        ctrl.idle(2);
        chk("bank open", 32'h0000_0008, 32'(o_bank_open));
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_PRECHARGE, 3'h3, 13'h0000);
        ctrl.idle(3);
        chk("bank closed", 32'h0, 32'(o_bank_open));
    endtask

    // Write, read back with auto precharge, then a masked rewrite
    task automatic t_write_read();
        logic [15:0] e [8];
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_ACTIVATE, 3'h0, 13'h0001);
        ctrl.idle(3);
        wr(3'h0, 13'h0000, 4, 2, pa, 8'h00);
        rd(3'h0, 13'h0400, 4, 3, 1'b1, pa);
        ctrl.idle(3);
        chk("auto precharge", 32'h0, 32'(o_bank_open));
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_ACTIVATE, 3'h0, 13'h0001);
        ctrl.idle(3);
        wr(3'h0, 13'h0000, 4, 2, pb, 8'h02);
        e = pb;
        e[1] = pa[1];
        rd(3'h0, 13'h0000, 4, 3, 1'b1, e);
    endtask

    // Additive latency two, then reads half a burst apart
    task automatic t_latency();
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_LOAD_MODE, dcb_pkg::MR_SEL_EXT, 13'h0010);
        ctrl.idle(2);
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_ACTIVATE, 3'h5, 13'h0002);
        ctrl.idle(3);
        wr(3'h5, 13'h0008, 4, 4, pb, 8'h00);
        rd(3'h5, 13'h0008, 4, 5, 1'b1, pb);
        fork
            ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_READ, 3'h5, 13'h0008);
            begin
                repeat (2) @(negedge ck);
                rd(3'h5, 13'h0008, 4, 5, 1'b0, pb);
            end
        join
    endtask

    // Burst of eight after a mode load with all banks idle
    task automatic t_burst8();
        logic [15:0] e [8];
        for (int i = 0; i < 8; i++) e[i] = ~pa[i];
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_PRECHARGE, 3'h0, 13'h0400);
        ctrl.idle(3);
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_LOAD_MODE, dcb_pkg::MR_SEL_MODE, 13'h0033);
        ctrl.idle(2);
        ctrl.cmd(1'b1, 1'b0, dcb_pkg::CMD_ACTIVATE, 3'h6, 13'h0003);
        ctrl.idle(3);
        wr(3'h6, 13'h0010, 8, 4, e, 8'h00);
        rd(3'h6, 13'h0010, 8, 5, 1'b1, e);
    endtask

    // Two long bursts through the write queue, second one half masked
    task automatic t_queue();
        logic [15:0] e [8];
        for (int i = 0; i < 8; i++) e[i] = i[0] ? pa[i] : pb[i];
        wr(3'h6, 13'h0018, 8, 4, pa, 8'h00);
        wr(3'h6, 13'h0018, 8, 4, pb, 8'haa);
        rd(3'h6, 13'h0018, 8, 5, 1'b1, e);
        chk("bank still open", 32'h0000_0040, 32'(o_bank_open));
        chk("strobe released", 32'h0, 32'(o_dqs_oe));
        chk("strobe complement idle", 32'h1, 32'(o_dqs_b));
        chk("recovery idle", 32'h0, 32'(o_wr_recovery));
        chk("lane idle", 32'h0, 32'(o_dq_oe));
    endtask

    // Main sequence
    initial begin
        for (int i = 0; i < 8; i++) begin
            pa[i] = 16'ha500 + 16'(i);
            pb[i] = 16'h5a00 + 16'(i * 17);
        end
        repeat (20) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        t_bank();
        t_write_read();
        t_latency();
        t_burst8();
        t_queue();
        complete_run();
    end

    // Watchdog: about four times the expected run
    initial begin
        #250_000;
        errors++;
        complete_run();
    end
endmodule // dcb_engine_tb
